// ===== event_status_pkg.sv
// package: register map, field layout, mode codes and carrier types for event status logic
package event_status_pkg;

	// ----------------------------------------------------------------
	// register offsets on the serial register port
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_FIFO_STATUS = 8'h00;
	localparam logic [7:0] ADDR_DATA_FIRST = 8'h01;
	localparam logic [7:0] ADDR_DATA_LAST = 8'h06;
	localparam logic [7:0] ADDR_FIFO_TRIGGER_SELECT = 8'h0A;
	localparam logic [7:0] ADDR_OPERATING_MODE_STATUS = 8'h0B;
	localparam logic [7:0] ADDR_EVENT_SOURCE_FLAGS = 8'h0C;
	localparam logic [7:0] ADDR_ORIENTATION_STATUS = 8'h10;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int TRIG_SEL_LSB = 2;
	localparam int TRIG_SEL_W = 4;
	localparam int GATE_FLAG_BIT = 7;
	localparam int NUM_FLAGS = 8;
	localparam int FLAG_SLEEP_WAKE = 7;
	localparam int FLAG_BUFFER = 6;
	localparam int FLAG_JOLT = 5;
	localparam int FLAG_ORIENTATION = 4;
	localparam int FLAG_TAP = 3;
	localparam int FLAG_FALL_MOTION = 2;
	localparam int FLAG_UNUSED = 1;
	localparam int FLAG_SAMPLE_READY = 0;

	// ----------------------------------------------------------------
	// reset values and codes
	// ----------------------------------------------------------------
	localparam logic [7:0] BYTE_ZERO = 8'h00;
	localparam logic [3:0] TRIG_SEL_RESET = 4'h0;
	localparam logic [1:0] MODE_STANDBY = 2'h0;
	localparam logic [1:0] MODE_WAKE = 2'h1;
	localparam logic [1:0] MODE_SLEEP = 2'h2;
	localparam int AGE_WIDTH = 5;
	localparam logic [AGE_WIDTH-1:0] AGE_RESET = 5'h00;

	// mode state, gray along standby -> wake -> sleep
	typedef enum logic [1:0] {
		ST_STANDBY = 2'b00,
		ST_WAKE = 2'b01,
		ST_SLEEP = 2'b11
	} mode_state_t;

	// one access on the register port
	typedef struct packed {
		logic rd;
		logic wr;
		logic [7:0] addr;
		logic [7:0] wdata;
	} reg_req_t;

	// function event levels, one bit per detector
	typedef struct packed {
		logic jolt;
		logic orientation;
		logic tap;
		logic fall_motion;
	} func_events_t;

endpackage : event_status_pkg

// ===== edge_flag.sv
// module: rising-edge sticky flag with set-over-clear priority
`timescale 1ns/1ps
module edge_flag (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic level,
	input wire logic clear,
	output logic rose,
	output logic flag
);

	logic level_q;

	// edge found against last cycle's level
	assign rose = level & ~level_q;

	// a new edge in the clearing cycle must not be lost, so set wins
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			level_q <= 1'b0;
			flag <= 1'b0;
		end else begin
			level_q <= level;
			flag <= rose | (flag & ~clear);
		end
	end

endmodule : edge_flag

// ===== event_source_and_mode_status.sv
// module: event source flags, operating mode tracking, gate error age and trigger select
// Summary of operation
// - four trigger select bits, reset zero
// - set select bit lets event trigger buffer
// - trigger status rising edge, cleared by source read
// - mode field: 00 standby, 01 wake, 10 sleep
// - gate error set on error, cleared when emptied
// - five-bit age counts sample periods since error
// - read-only source flags in fixed bit order
// - flags set on rising edge, held until read
// - status read at zero keeps sample-ready flag
// - sleep/wake flag on transition, cleared by mode read
// - idle past limit: wake to sleep, low rate
// - selected event in sleep: wake, high rate
// - buffer flag on overflow or count at watermark
// - jolt flag from event-active, cleared by its read
// - orientation flag from change, cleared by its read
// - tap flag from event-active, cleared by its read
// - fall/motion flag from event-active, cleared by read
// - sample-ready flag from new data or overrun
`timescale 1ns/1ps
module event_source_and_mode_status #(
	parameter int IDLE_W = 8,
	parameter int FILL_W = 6,
	parameter logic [7:0] JOLT_SOURCE_ADDR = 8'h14,
	parameter logic [7:0] TAP_SOURCE_ADDR = 8'h18,
	parameter logic [7:0] FALL_MOTION_SOURCE_ADDR = 8'h1C
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire event_status_pkg::reg_req_t reg_req,
	output logic [7:0] reg_rdata,
	output logic reg_rdata_valid,
	input wire logic sample_tick,
	input wire logic active_mode,
	input wire logic auto_sleep_enable,
	input wire logic [IDLE_W-1:0] idle_limit_setting,
	input wire logic [5:0] wake_source_select,
	input wire logic [5:0] interrupt_enable,
	input wire event_status_pkg::func_events_t func_events,
	input wire logic xyz_new_data,
	input wire logic xyz_overrun,
	input wire logic buffer_overflow,
	input wire logic [FILL_W-1:0] buffer_fill_count,
	input wire logic [FILL_W-1:0] buffer_watermark,
	input wire logic gate_error_detect,
	output logic [1:0] operating_mode_field,
	output logic low_rate_select,
	output logic fifo_trigger,
	output logic [3:0] trigger_status,
	output logic [7:0] event_source_flags,
	output logic gate_error_flag,
	output logic [4:0] gate_error_age
);
	import event_status_pkg::*;

	// ----------------------------------------------------------------
	// elaboration checks
	// ----------------------------------------------------------------
	if (IDLE_W < 1 || IDLE_W > 16) begin : g_bad_idle
		$error("idle counter width out of range");
	end
	if (FILL_W < 1) begin : g_bad_fill
		$error("fill count width must be positive");
	end

	// enable and wake-select bit order: buffer, jolt, orient, tap, fall, ready
	localparam int EN_BUFFER = 5;
	localparam int EN_JOLT = 4;
	localparam int EN_ORIENTATION = 3;
	localparam int EN_TAP = 2;
	localparam int EN_FALL_MOTION = 1;
	localparam int EN_SAMPLE_READY = 0;
	localparam logic [AGE_WIDTH-1:0] AGE_MAX = 5'h1F;
	localparam logic [IDLE_W:0] IDLE_ONE = {{IDLE_W{1'b0}}, 1'b1};
	localparam logic [IDLE_W:0] IDLE_MAX = {(IDLE_W+1){1'b1}};

	// ----------------------------------------------------------------
	// read decode
	// ----------------------------------------------------------------
	function automatic logic is_read(input reg_req_t req, input logic [7:0] addr);
		is_read = req.rd && (req.addr == addr);
	endfunction : is_read

	wire rd_mode = is_read(reg_req, ADDR_OPERATING_MODE_STATUS);
	wire rd_fifo_status = is_read(reg_req, ADDR_FIFO_STATUS);
	// data bytes only; the status byte at zero is excluded here
	wire rd_xyz = reg_req.rd && (reg_req.addr >= ADDR_DATA_FIRST)
		&& (reg_req.addr <= ADDR_DATA_LAST);
	wire rd_jolt = is_read(reg_req, JOLT_SOURCE_ADDR);
	wire rd_orient = is_read(reg_req, ADDR_ORIENTATION_STATUS);
	wire rd_tap = is_read(reg_req, TAP_SOURCE_ADDR);
	wire rd_fall = is_read(reg_req, FALL_MOTION_SOURCE_ADDR);
	wire wr_trig = reg_req.wr && (reg_req.addr == ADDR_FIFO_TRIGGER_SELECT);

	// ----------------------------------------------------------------
	// event levels feeding the source flags
	// ----------------------------------------------------------------
	logic sleep_wake_pulse;
	wire watermark_hit = (buffer_watermark != {FILL_W{1'b0}})
		&& (buffer_fill_count == buffer_watermark);
	wire [NUM_FLAGS-1:0] flag_level;
	wire [NUM_FLAGS-1:0] flag_clear;
	wire [NUM_FLAGS-1:0] flag_rose;
	wire [NUM_FLAGS-1:0] flag_q;

	assign flag_level[FLAG_SLEEP_WAKE] = sleep_wake_pulse;
	assign flag_level[FLAG_BUFFER] = interrupt_enable[EN_BUFFER]
		& (buffer_overflow | watermark_hit);
	assign flag_level[FLAG_JOLT] = interrupt_enable[EN_JOLT] & func_events.jolt;
	assign flag_level[FLAG_ORIENTATION] = interrupt_enable[EN_ORIENTATION]
		& func_events.orientation;
	assign flag_level[FLAG_TAP] = interrupt_enable[EN_TAP] & func_events.tap;
	assign flag_level[FLAG_FALL_MOTION] = interrupt_enable[EN_FALL_MOTION]
		& func_events.fall_motion;
	assign flag_level[FLAG_UNUSED] = 1'b0;
	assign flag_level[FLAG_SAMPLE_READY] = interrupt_enable[EN_SAMPLE_READY]
		& (xyz_new_data | xyz_overrun);

	// each flag cleared only by its own function's register read
	assign flag_clear[FLAG_SLEEP_WAKE] = rd_mode;
	assign flag_clear[FLAG_BUFFER] = rd_fifo_status;
	assign flag_clear[FLAG_JOLT] = rd_jolt;
	assign flag_clear[FLAG_ORIENTATION] = rd_orient;
	assign flag_clear[FLAG_TAP] = rd_tap;
	assign flag_clear[FLAG_FALL_MOTION] = rd_fall;
	assign flag_clear[FLAG_UNUSED] = 1'b0;
	assign flag_clear[FLAG_SAMPLE_READY] = rd_xyz;

	// one sticky edge cell per source bit
	for (genvar i = 0; i < NUM_FLAGS; i++) begin : g_flag
		edge_flag u_flag (
			.ref_clk(ref_clk),
			.rst_n(rst_n),
			.level(flag_level[i]),
			.clear(flag_clear[i]),
			.rose(flag_rose[i]),
			.flag(flag_q[i])
		);
	end

	// bit 1 is forced low so stray activity can never show
	assign event_source_flags = flag_q & ~(8'h01 << FLAG_UNUSED);

	// ----------------------------------------------------------------
	// fifo trigger selection and trigger status
	// ----------------------------------------------------------------
	logic [3:0] trig_sel;
	wire [3:0] trig_level;
	wire [3:0] trig_clear;
	wire [3:0] trig_rise;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			trig_sel <= TRIG_SEL_RESET;
		end else if (wr_trig) begin
			trig_sel <= reg_req.wdata[TRIG_SEL_LSB +: TRIG_SEL_W];
		end
	end

	// select order high to low: jolt, orientation, tap, fall/motion
	assign trig_level = trig_sel & func_events;
	assign trig_clear = {rd_jolt, rd_orient, rd_tap, rd_fall};

	for (genvar t = 0; t < 4; t++) begin : g_trig
		edge_flag u_trig (
			.ref_clk(ref_clk),
			.rst_n(rst_n),
			.level(trig_level[t]),
			.clear(trig_clear[t]),
			.rose(trig_rise[t]),
			.flag(trigger_status[t])
		);
	end

	// trigger pulse registered so the buffer engine sees a clean strobe
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			fifo_trigger <= 1'b0;
		end else begin
			fifo_trigger <= |trig_rise;
		end
	end

	// ----------------------------------------------------------------
	// operating mode machine and idle timer
	// ----------------------------------------------------------------
	mode_state_t state, next_state;
	logic [IDLE_W:0] idle_count;
	wire [5:0] func_rise = {flag_rose[FLAG_BUFFER], flag_rose[FLAG_JOLT],
		flag_rose[FLAG_ORIENTATION], flag_rose[FLAG_TAP],
		flag_rose[FLAG_FALL_MOTION], flag_rose[FLAG_SAMPLE_READY]};
	wire activity = |func_rise;
	wire wake_event = |(func_rise & wake_source_select);
	wire idle_expired = idle_count > {1'b0, idle_limit_setting};

	always_comb begin
		next_state = state;
		unique case (state)
			ST_STANDBY: begin
				if (active_mode) begin
					next_state = ST_WAKE;
				end
			end
			ST_WAKE: begin
				if (!active_mode) begin
					next_state = ST_STANDBY;
				end else if (auto_sleep_enable && idle_expired) begin
					next_state = ST_SLEEP;
				end
			end
			ST_SLEEP: begin
				if (!active_mode) begin
					next_state = ST_STANDBY;
				end else if (wake_event) begin
					next_state = ST_WAKE;
				end
			end
			default: begin
				next_state = ST_STANDBY;
			end
		endcase
	end

	// mode field code differs from the gray state code
	function automatic logic [1:0] mode_code(input mode_state_t s);
		unique case (s)
			ST_WAKE: mode_code = MODE_WAKE;
			ST_SLEEP: mode_code = MODE_SLEEP;
			default: mode_code = MODE_STANDBY;
		endcase
	endfunction : mode_code

	wire wake_sleep_move = ((state == ST_WAKE) && (next_state == ST_SLEEP))
		|| ((state == ST_SLEEP) && (next_state == ST_WAKE));

	// state, outputs and transition pulse
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= ST_STANDBY;
			operating_mode_field <= MODE_STANDBY;
			low_rate_select <= 1'b0;
			sleep_wake_pulse <= 1'b0;
		end else begin
			state <= next_state;
			operating_mode_field <= mode_code(next_state);
			low_rate_select <= (next_state == ST_SLEEP);
			sleep_wake_pulse <= wake_sleep_move;
		end
	end

	// idle timer counts sample periods with no interrupt, saturating
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			idle_count <= '0;
		end else if (activity || (state != ST_WAKE)) begin
			idle_count <= '0;
		end else if (sample_tick && (idle_count != IDLE_MAX)) begin
			idle_count <= idle_count + IDLE_ONE;
		end
	end

	// ----------------------------------------------------------------
	// gate error flag and age
	// ----------------------------------------------------------------
	wire buffer_empty = (buffer_fill_count == {FILL_W{1'b0}});

	// a fresh error beats an empty buffer in the same cycle
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			gate_error_flag <= 1'b0;
		end else begin
			gate_error_flag <= gate_error_detect
				| (gate_error_flag & ~buffer_empty);
		end
	end

	// age saturates rather than wraps, so a stale error never looks young
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			gate_error_age <= AGE_RESET;
		end else if (!gate_error_flag || (buffer_empty && !gate_error_detect)) begin
			gate_error_age <= AGE_RESET;
		end else if (sample_tick && (gate_error_age != AGE_MAX)) begin
			gate_error_age <= gate_error_age + 5'h01;
		end
	end

	// ----------------------------------------------------------------
	// register read port
	// ----------------------------------------------------------------
	wire [7:0] trig_byte = {2'b00, trig_sel, 2'b00};
	wire [7:0] mode_byte = {gate_error_flag, gate_error_age, operating_mode_field};
	wire [7:0] read_mux = (reg_req.addr == ADDR_FIFO_TRIGGER_SELECT) ? trig_byte
		: (reg_req.addr == ADDR_OPERATING_MODE_STATUS) ? mode_byte
		: (reg_req.addr == ADDR_EVENT_SOURCE_FLAGS) ? event_source_flags
		: BYTE_ZERO;

	// read data captured before the same read clears any flag
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= BYTE_ZERO;
			reg_rdata_valid <= 1'b0;
		end else begin
			reg_rdata_valid <= reg_req.rd;
			if (reg_req.rd) begin
				reg_rdata <= read_mux;
			end
		end
	end

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	property p_trig_write;
		@(posedge ref_clk) disable iff (!rst_n)
		wr_trig |=> (trig_sel == $past(reg_req.wdata[5:2]));
	endproperty
	a_trig_write: assert property (p_trig_write)
		else $error("trigger select did not take written value");

	property p_trig_gated;
		@(posedge ref_clk) disable iff (!rst_n)
		(trig_sel == 4'h0) ##1 (trig_sel == 4'h0) |=> !fifo_trigger;
	endproperty
	a_trig_gated: assert property (p_trig_gated)
		else $error("fifo trigger with no function selected");

	property p_trig_status;
		@(posedge ref_clk) disable iff (!rst_n)
		$rose(trig_level[3]) |=> trigger_status[3];
	endproperty
	a_trig_status: assert property (p_trig_status)
		else $error("trigger status missed a rising edge");

	property p_standby;
		@(posedge ref_clk) disable iff (!rst_n)
		!active_mode |=> (operating_mode_field == 2'b00) && !low_rate_select;
	endproperty
	a_standby: assert property (p_standby)
		else $error("mode field not standby while inactive");

	property p_gate_set;
		@(posedge ref_clk) disable iff (!rst_n)
		gate_error_detect |=> gate_error_flag ##1 (gate_error_flag || $past(buffer_empty));
	endproperty
	a_gate_set: assert property (p_gate_set)
		else $error("gate error flag not set after error");

	property p_age_count;
		@(posedge ref_clk) disable iff (!rst_n)
		(gate_error_flag && !buffer_empty && sample_tick && gate_error_age < 5'h1F)
			|=> (gate_error_age == $past(gate_error_age) + 5'h01);
	endproperty
	a_age_count: assert property (p_age_count)
		else $error("gate error age did not advance");

	property p_unused_zero;
		@(posedge ref_clk) disable iff (!rst_n)
		is_read(reg_req, ADDR_EVENT_SOURCE_FLAGS) |=> (reg_rdata[1] == 1'b0)
			&& (reg_rdata == $past(event_source_flags));
	endproperty
	a_unused_zero: assert property (p_unused_zero)
		else $error("source register read returned wrong value");

	property p_ready_kept;
		@(posedge ref_clk) disable iff (!rst_n)
		(rd_fifo_status && flag_q[FLAG_SAMPLE_READY]) |=> flag_q[FLAG_SAMPLE_READY];
	endproperty
	a_ready_kept: assert property (p_ready_kept)
		else $error("status read cleared sample-ready flag");

	property p_mode_read_clear;
		@(posedge ref_clk) disable iff (!rst_n)
		(rd_mode && !flag_rose[FLAG_SLEEP_WAKE]) |=> !flag_q[FLAG_SLEEP_WAKE];
	endproperty
	a_mode_read_clear: assert property (p_mode_read_clear)
		else $error("mode read did not clear sleep/wake flag");

	sequence s_idle_out;
		(state == ST_WAKE) && active_mode && auto_sleep_enable && idle_expired;
	endsequence
	sequence s_asleep_flagged;
		(operating_mode_field == 2'b10) && low_rate_select ##2 flag_q[FLAG_SLEEP_WAKE];
	endsequence
	property p_go_sleep;
		@(posedge ref_clk) disable iff (!rst_n)
		s_idle_out |=> s_asleep_flagged;
	endproperty
	a_go_sleep: assert property (p_go_sleep)
		else $error("idle timeout did not enter sleep");

	property p_wake_up;
		@(posedge ref_clk) disable iff (!rst_n)
		((state == ST_SLEEP) && active_mode && wake_event)
			|=> (operating_mode_field == 2'b01) && !low_rate_select;
	endproperty
	a_wake_up: assert property (p_wake_up)
		else $error("selected event did not wake");

endmodule : event_source_and_mode_status

// ===== host_model.sv
// partner: host processor issuing single-byte register reads and writes
`timescale 1ns/1ps
module host_model (
	input wire logic ref_clk,
	output event_status_pkg::reg_req_t reg_req,
	input wire logic [7:0] reg_rdata,
	input wire logic reg_rdata_valid
);
	import event_status_pkg::*;
	// ------------------------------------------------
	// bus cycles
	// ------------------------------------------------
	initial begin
		reg_req = '0;
	end
	// one strobe cycle, then a bounded wait for the answer
	task automatic rd(input logic [7:0] addr, output logic [7:0] data);
		int n;
		@(posedge ref_clk);
		reg_req <= '{rd: 1'b1, wr: 1'b0, addr: addr, wdata: 8'h00};
		@(posedge ref_clk);
		reg_req <= '0;
		#1;
		for (n = 0; n < 4 && reg_rdata_valid !== 1'b1; n++) begin
			@(posedge ref_clk);
			#1;
		end
		// no answer leaves data unknown so the compare fails
		data = (reg_rdata_valid === 1'b1) ? reg_rdata : 8'hXX;
	endtask : rd
	// writes have no answer; the strobe is dropped at the next edge
	task automatic wr(input logic [7:0] addr, input logic [7:0] data);
		@(posedge ref_clk);
		reg_req <= '{rd: 1'b0, wr: 1'b1, addr: addr, wdata: data};
		@(posedge ref_clk);
		reg_req <= '0;
	endtask : wr
endmodule : host_model

// ===== tb.sv
// testbench: event source flags, mode tracking, gate error age, trigger select
`timescale 1ns/1ps
module tb;
	import event_status_pkg::*;
	localparam logic [7:0] JOLT_ADDR = 8'h14;
	localparam logic [7:0] TAP_ADDR = 8'h18;
	localparam logic [7:0] FALL_ADDR = 8'h1C;
	localparam logic [7:0] SRC = ADDR_EVENT_SOURCE_FLAGS;
	localparam logic [7:0] MODE = ADDR_OPERATING_MODE_STATUS;
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	reg_req_t reg_req;
	logic [7:0] reg_rdata;
	logic reg_rdata_valid;
	logic sample_tick = 1'b0;
	logic active_mode = 1'b0;
	logic auto_sleep_enable = 1'b0;
	logic [7:0] idle_limit_setting = 8'h03;
	logic [5:0] wake_source_select = 6'h10;
	logic [5:0] interrupt_enable = 6'h3F;
	func_events_t func_events = '0;
	logic xyz_new_data = 1'b0;
	logic xyz_overrun = 1'b0;
	logic buffer_overflow = 1'b0;
	logic [5:0] buffer_fill_count = 6'h00;
	logic [5:0] buffer_watermark = 6'h00;
	logic gate_error_detect = 1'b0;
	logic [1:0] operating_mode_field;
	logic low_rate_select;
	logic fifo_trigger;
	logic [3:0] trigger_status;
	logic [7:0] event_source_flags;
	logic gate_error_flag;
	logic [4:0] gate_error_age;
	int mismatches = 0;
	int n_tests = 0;
	int seed = 32'hd5d0;
	// model state: clearing address per function, expected trigger count
	int clr_q[$] = '{JOLT_ADDR, ADDR_ORIENTATION_STATUS, TAP_ADDR, FALL_ADDR};
	logic [7:0] exp_trig = 8'h00;
	logic [7:0] trig_seen = 8'h00;
	logic [7:0] got;
	logic [3:0] sel;

	// ------------------------------------------------
	// clock, design, partner
	// ------------------------------------------------
	initial begin
		forever #10 ref_clk = ~ref_clk;
	end
	event_source_and_mode_status #(.IDLE_W(8), .FILL_W(6), .JOLT_SOURCE_ADDR(JOLT_ADDR),
		.TAP_SOURCE_ADDR(TAP_ADDR), .FALL_MOTION_SOURCE_ADDR(FALL_ADDR)) i_dut (
		.ref_clk(ref_clk), .rst_n(rst_n), .reg_req(reg_req), .reg_rdata(reg_rdata),
		.reg_rdata_valid(reg_rdata_valid), .sample_tick(sample_tick),
		.active_mode(active_mode), .auto_sleep_enable(auto_sleep_enable),
		.idle_limit_setting(idle_limit_setting), .wake_source_select(wake_source_select),
		.interrupt_enable(interrupt_enable), .func_events(func_events),
		.xyz_new_data(xyz_new_data), .xyz_overrun(xyz_overrun),
		.buffer_overflow(buffer_overflow), .buffer_fill_count(buffer_fill_count),
		.buffer_watermark(buffer_watermark), .gate_error_detect(gate_error_detect),
		.operating_mode_field(operating_mode_field), .low_rate_select(low_rate_select),
		.fifo_trigger(fifo_trigger), .trigger_status(trigger_status),
		.event_source_flags(event_source_flags), .gate_error_flag(gate_error_flag),
		.gate_error_age(gate_error_age));
	host_model i_host (.ref_clk(ref_clk), .reg_req(reg_req), .reg_rdata(reg_rdata),
		.reg_rdata_valid(reg_rdata_valid));
	// trigger is a one-cycle pulse, so every edge is counted
	always @(posedge ref_clk) begin
		if (fifo_trigger === 1'b1) trig_seen <= trig_seen + 8'h01;
	end

	// ------------------------------------------------
	// helpers
	// ------------------------------------------------
	// ends just past the edge so outputs have settled
	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask : cyc
	task automatic tick(input int n);
		repeat (n) begin
			@(posedge ref_clk);
			sample_tick <= 1'b1;
			@(posedge ref_clk);
			sample_tick <= 1'b0;
		end
	endtask : tick
	task automatic check_reg(input string what, input logic [7:0] exp, input logic [7:0] seen);
		n_tests++;
		if (seen !== exp) begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask : check_reg
	task automatic check_pin(input string what, input logic [7:0] exp, input logic [7:0] seen);
		n_tests++;
		if (seen !== exp) begin
			mismatches++;
			$display("ERROR pin %s expected %h seen %h", what, exp, seen);
		end
	endtask : check_pin
	task automatic rd_check(input logic [7:0] addr, input logic [7:0] exp, input string what);
		i_host.rd(addr, got);
		check_reg(what, exp, got);
	endtask : rd_check
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : print_verdict

	// ------------------------------------------------
	// watchdog and main sequence
	// ------------------------------------------------
	initial begin
		#200000;
		mismatches++;
		print_verdict();
	end
	initial begin
		cyc(19);
		@(posedge ref_clk);
		rst_n <= 1'b1;
		cyc(2);
		rd_check(ADDR_FIFO_TRIGGER_SELECT, 8'h00, "select reset");
		rd_check(MODE, 8'h00, "mode reset");
		rd_check(SRC, 8'h00, "flags reset");
		rd_check(8'h30, 8'h00, "unmapped");
		sel = 4'($random(seed));
		i_host.wr(ADDR_FIFO_TRIGGER_SELECT, {2'b11, sel, 2'b11});
		i_host.wr(SRC, 8'hFF);
		rd_check(ADDR_FIFO_TRIGGER_SELECT, {2'b00, sel, 2'b00}, "select");
		rd_check(SRC, 8'h00, "flags read-only");
		// each function event in turn, cleared by its own source read
		for (int i = 0; i < 4; i++) begin
			@(posedge ref_clk);
			func_events <= 4'h8 >> i;
			exp_trig = exp_trig + 8'(sel[3-i]);
			cyc(3);
			check_pin("trigger count", exp_trig, trig_seen);
			check_pin("trigger status set", {4'h0, sel & (4'h8 >> i)}, {4'h0, trigger_status});
			rd_check(SRC, 8'h20 >> i, "function flag");
			i_host.rd(8'(clr_q[i]), got);
			@(posedge ref_clk);
			func_events <= '0;
			cyc(2);
			rd_check(SRC, 8'h00, "function flag cleared");
			check_pin("trigger status", 8'h00, {4'h0, trigger_status});
		end
		// new data, then overrun: status read keeps the flag, data read clears it
		for (int j = 0; j < 2; j++) begin
			@(posedge ref_clk);
			xyz_new_data <= (j == 0);
			xyz_overrun <= (j == 1);
			cyc(3);
			i_host.rd(ADDR_FIFO_STATUS, got);
			cyc(2);
			rd_check(SRC, 8'h01, "ready kept");
			i_host.rd(ADDR_DATA_FIRST + 8'({$random(seed)} % 6), got);
			@(posedge ref_clk);
			xyz_new_data <= 1'b0;
			xyz_overrun <= 1'b0;
			cyc(2);
			rd_check(SRC, 8'h00, "ready cleared");
		end
		// watermark match, then overflow
		for (int j = 0; j < 2; j++) begin
			@(posedge ref_clk);
			buffer_watermark <= (j == 0) ? 6'h04 : 6'h00;
			buffer_fill_count <= 6'h04;
			buffer_overflow <= (j == 1);
			cyc(3);
			rd_check(SRC, 8'h40, "buffer flag");
			check_pin("unused bit", 8'h00, {7'h00, event_source_flags[FLAG_UNUSED]});
			i_host.rd(ADDR_FIFO_STATUS, got);
			@(posedge ref_clk);
			buffer_watermark <= 6'h00;
			buffer_fill_count <= 6'h05;
			buffer_overflow <= 1'b0;
			cyc(2);
			rd_check(SRC, 8'h00, "buffer cleared");
		end
		// gate error ages while the buffer holds data, clears when emptied
		@(posedge ref_clk);
		gate_error_detect <= 1'b1;
		@(posedge ref_clk);
		gate_error_detect <= 1'b0;
		tick(3);
		cyc(2);
		rd_check(MODE, {1'b1, 5'h03, MODE_STANDBY}, "gate age");
		check_pin("gate flag", 8'h01, {7'h00, gate_error_flag});
		check_pin("gate age", 8'h03, {3'h0, gate_error_age});
		@(posedge ref_clk);
		buffer_fill_count <= 6'h00;
		cyc(3);
		rd_check(MODE, {1'b0, 5'h00, MODE_STANDBY}, "gate cleared");
		check_pin("gate flag cleared", 8'h00, {7'h00, gate_error_flag});
		check_pin("gate age cleared", 8'h00, {3'h0, gate_error_age});
		// wake, idle past the limit into sleep, then woken by a jolt
		@(posedge ref_clk);
		active_mode <= 1'b1;
		auto_sleep_enable <= 1'b1;
		cyc(2);
		check_pin("mode", {6'h00, MODE_WAKE}, {6'h00, operating_mode_field});
		tick(3);
		cyc(4);
		check_pin("mode at limit", {6'h00, MODE_WAKE}, {6'h00, operating_mode_field});
		tick(1);
		cyc(4);
		check_pin("mode", {6'h00, MODE_SLEEP}, {6'h00, operating_mode_field});
		check_pin("low rate", 8'h01, {7'h00, low_rate_select});
		rd_check(SRC, 8'h80, "sleep flag");
		rd_check(MODE, {6'h00, MODE_SLEEP}, "mode register");
		rd_check(SRC, 8'h00, "sleep flag cleared");
		// jolt alone selected as trigger, so the waking edge also triggers
		i_host.wr(ADDR_FIFO_TRIGGER_SELECT, 8'h20);
		exp_trig = exp_trig + 8'h01;
		@(posedge ref_clk);
		func_events <= 4'h8;
		cyc(5);
		check_pin("trigger count", exp_trig, trig_seen);
		check_pin("trigger status", 8'h08, {4'h0, trigger_status});
		check_pin("mode", {6'h00, MODE_WAKE}, {6'h00, operating_mode_field});
		check_pin("low rate", 8'h00, {7'h00, low_rate_select});
		rd_check(SRC, 8'hA0, "wake flags");
		@(posedge ref_clk);
		active_mode <= 1'b0;
		cyc(3);
		check_pin("mode", {6'h00, MODE_STANDBY}, {6'h00, operating_mode_field});
		print_verdict();
	end
endmodule : tb
